// File: bench/srxb_char_src.sv
module srxb_char_src (
	input  wire logic       clk,
	output logic            rx_char_valid,
	output logic      [7:0] rx_char_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		rx_char_valid = 1'b0;
		rx_char_data  = 8'h00;
	end

	// one completed character per call; between characters the data
	// lines show the inverse so a stale byte can never pass for valid
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_char_valid <= 1'b1;
		rx_char_data  <= b;
		@(posedge clk);
		rx_char_valid <= 1'b0;
		rx_char_data  <= ~b;
	endtask : send
endmodule : srxb_char_src

// File: bench/srxb_top_checker.sv
module srxb_top_checker
	import srxb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [15:0] bus_rdata,
	input wire logic        rx_char_valid,
	input wire logic [7:0]  rx_char_data,
	input wire logic        sample_tick,
	input wire logic        bit_tick,
	input wire logic        irq
);
	localparam logic [6:0] TRIGS [4] = '{TRIG_CODE0, TRIG_CODE1, TRIG_CODE2, TRIG_CODE3};
	localparam logic [4:0] HALVES [5] = '{HALF_S16, HALF_S5, HALF_S11, HALF_S13, HALF_S29};
	logic [7:0]  div;
	srxb_mode_t  mode;
	logic [1:0]  trig_code;
	logic [6:0]  cnt;
	logic [19:0] s_gap, b_gap, s_per, b_per;
	logic [4:0]  half;
	logic        arm;
	logic        cfg_wr;

	assign cfg_wr = bus_wr && (bus_addr == ADDR_MODE || bus_addr == ADDR_DIVISOR);
	assign half = mode.sync_mode ? HALF_SYNC : mode.sampling > 3'h4 ? HALF_S16 : HALVES[mode.sampling];
	assign s_per = 20'(div + 9'h001) << (2 * mode.prescale);
	assign b_per = s_per * 20'(half);

	always_ff @(posedge clk) begin
		if (rst) begin
			div       <= DIVISOR_RESET;
			mode      <= '0;
			trig_code <= 2'h0;
		end else if (bus_wr) begin
			if (bus_addr == ADDR_DIVISOR)
				div <= bus_wdata[7:0];
			if (bus_addr == ADDR_MODE)
				mode <= bus_wdata[MODE_WIDTH-1:0];
			if (bus_addr == ADDR_FCTRL)
				trig_code <= bus_wdata[FC_TRIG_LSB +: 2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || (bus_wr && bus_addr == ADDR_FCTRL && bus_wdata[FC_RESET_BIT]))
			cnt <= 7'h00;
		else
			cnt <= cnt + 7'(rx_char_valid && cnt != FIFO_FULL)
				- 7'(bus_rd && bus_addr == ADDR_RXDATA && cnt != 7'h00);
	end

	// the first period after a divisor or mode write has no fixed phase
	always_ff @(posedge clk) begin
		s_gap <= sample_tick ? 20'h00001 : s_gap + 20'h00001;
		b_gap <= bit_tick ? 20'h00001 : b_gap + 20'h00001;
		arm   <= (rst || cfg_wr) ? 1'b0 : (arm | bit_tick);
	end

	a_reset_clears: assert property (@(posedge clk) rst |=> bus_rdata == 16'h0000 && !irq)
		else $error("reset left read data or interrupt active");
	a_rdata_quiet: assert property (@(posedge clk) disable iff (rst)
		!bus_rd |=> bus_rdata == 16'h0000)
		else $error("read data present without a read");
	a_divisor_read: assert property (@(posedge clk) disable iff (rst)
		bus_rd && bus_addr == ADDR_DIVISOR |=> bus_rdata == {8'h00, div})
		else $error("divisor read back wrong");
	a_count_read: assert property (@(posedge clk) disable iff (rst)
		bus_rd && bus_addr == ADDR_FCOUNT |=> bus_rdata[6:0] == $past(cnt))
		else $error("fifo count wrong");
	a_count_max: assert property (@(posedge clk) disable iff (rst)
		bus_rd && bus_addr == ADDR_FCOUNT |=> bus_rdata <= 16'(FIFO_FULL))
		else $error("fifo count above depth");
	a_fill_sets: assert property (@(posedge clk) disable iff (rst)
		bus_rd && bus_addr == ADDR_STATUS && $past(cnt) >= $past(TRIGS[trig_code])
		|=> bus_rdata[ST_FILL_BIT])
		else $error("fill flag missing at trigger level");
	a_sample_period: assert property (@(posedge clk) disable iff (rst)
		sample_tick && arm |-> s_gap == s_per)
		else $error("sample tick spacing wrong");
	a_bit_period: assert property (@(posedge clk) disable iff (rst)
		bit_tick && arm |-> b_gap == b_per)
		else $error("bit tick spacing wrong");
endmodule : srxb_top_checker

bind srxb_top srxb_top_checker u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
	.sample_tick(sample_tick), .bit_tick(bit_tick), .irq(irq));

// File: bench/srxb_top_test.sv
module srxb_top_test
	import srxb_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  bus_addr = 8'h00;
	logic [15:0] bus_wdata = 16'h0000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [15:0] bus_rdata, rdata;
	logic        rx_char_valid, sample_tick, bit_tick, irq;
	logic [7:0]  rx_char_data;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          last, gap;
	int          hv [6] = '{16, 5, 11, 13, 29, 2};

	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	srxb_char_src src (.clk(clk), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));
	srxb_top dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.sample_tick(sample_tick), .bit_tick(bit_tick), .irq(irq));

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		rdata = bus_rdata;
	endtask : rd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// the first two gaps after a mode change are thrown away; only the third is kept
	task automatic period(input logic which, output int g);
		int n;
		n = 0;
		g = 0;
		repeat (3) begin
			g = 0;
			do begin
				@(negedge clk);
				g++;
				n++;
			end while (!(which ? bit_tick : sample_tick) && n < 20000);
		end
	endtask : period

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial begin
		#(100 * 60000);
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_DIVISOR);
		chk(rdata, 16'h00ff);
		rd(ADDR_STATUS);
		chk(rdata, 16'h0000);
		wr(ADDR_DIVISOR, 16'h005a);
		rd(ADDR_DIVISOR);
		chk(rdata, 16'h005a);
		rd(8'h20);
		chk(rdata, 16'h0000);
		$display("test registers done");

		wr(ADDR_DIVISOR, 16'h0001);
		for (int s = 0; s < 6; s++) begin
			wr(ADDR_MODE, s == 5 ? 16'h0021 : 16'((s << 2) | 1));
			period(1'b1, gap);
			chk(16'(gap), 16'(8 * hv[s]));
		end
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_MODE, 16'(p));
			period(1'b0, gap);
			chk(16'(gap), 16'(2 << (2 * p)));
		end
		$display("test bit rate done");

		wr(ADDR_MODE, 16'h0000);
		wr(ADDR_DIVISOR, 16'h0000);
		wr(ADDR_IRQ_MASK, 16'h0007);
		wr(ADDR_FCTRL, 16'h0042);
		for (int i = 0; i < 15; i++)
			src.send(8'(i + 8'h30));
		rd(ADDR_FCOUNT);
		chk(rdata & 16'h007f, 16'h000f);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0000);
		chk(16'(irq), 16'h0000);
		src.send(8'h3f);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0002);
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0002);
		chk(16'(irq), 16'h0001);
		rd(ADDR_RXDATA);
		chk(rdata, 16'h0030);
		// count is below trigger and flag was seen: only a written 1 keeps it
		wr(ADDR_STATUS, 16'h0003);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0002);
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0000);
		wr(ADDR_IRQ_STAT, 16'h0007);
		@(negedge clk);
		chk(16'(irq), 16'h0000);
		for (int i = 0; i < 14; i++)
			rd(ADDR_RXDATA);
		$display("test fill flag done");

		src.send(8'h41);
		repeat (200) @(posedge clk);
		src.send(8'h42);
		last = cyc;
		while (cyc < last + 225) @(posedge clk);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0001, 16'h0000);
		while (cyc < last + 255) @(posedge clk);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0001, 16'h0001);
		chk(16'(irq), 16'h0001);
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0001, 16'h0001);
		repeat (3) rd(ADDR_RXDATA);
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0001, 16'h0000);
		rd(ADDR_RXDATA);
		rd(ADDR_FCOUNT);
		chk(rdata, 16'h0000);
		$display("test idle flag done");

		wr(ADDR_FCTRL, 16'h0002);
		src.send(8'h55);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0002);
		for (int i = 0; i < 64; i++)
			src.send(8'(i));
		rd(ADDR_FCOUNT);
		chk(rdata, 16'h0040);
		rd(ADDR_IRQ_STAT);
		chk(rdata & 16'h0004, 16'h0004);
		wr(ADDR_IRQ_MASK, 16'h0000);
		@(negedge clk);
		chk(16'(irq), 16'h0000);
		// trigger code 3 without fifo reset: level 48
		wr(ADDR_FCTRL, 16'h00c0);
		for (int i = 0; i < 17; i++)
			rd(ADDR_RXDATA);
		rd(ADDR_STATUS);
		wr(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0000);
		src.send(8'h66);
		rd(ADDR_STATUS);
		chk(rdata & 16'h0002, 16'h0002);
		$display("test overrun done");
		end_of_test();
	end
endmodule : srxb_top_test

// File: inc/srxb_pkg.sv
package srxb_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_DIVISOR  = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_FCTRL    = 8'h0c;
	localparam logic [7:0] ADDR_FCOUNT   = 8'h10;
	localparam logic [7:0] ADDR_RXDATA   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

	// serial mode register layout
	localparam int MODE_PRE_LSB  = 0;
	localparam int MODE_SAMP_LSB = 2;
	localparam int MODE_SYNC_BIT = 5;
	localparam int MODE_WIDTH    = 6;

	// status register layout
	localparam int ST_IDLE_BIT = 0;
	localparam int ST_FILL_BIT = 1;

	// fifo control register layout
	localparam int FC_RESET_BIT = 1;
	localparam int FC_TRIG_LSB  = 6;

	// interrupt status layout
	localparam int IRQ_IDLE_BIT    = 0;
	localparam int IRQ_FILL_BIT    = 1;
	localparam int IRQ_OVERRUN_BIT = 2;
	localparam int IRQ_WIDTH       = 3;

	localparam int FIFO_DEPTH = 64;
	localparam int PTR_W      = 6;
	localparam int CNT_W      = 7;

	localparam logic [7:0]       DIVISOR_RESET = 8'hff;
	localparam logic [CNT_W-1:0] FIFO_FULL     = 7'h40;

	// receive trigger levels by code
	localparam logic [CNT_W-1:0] TRIG_CODE0 = 7'h01;
	localparam logic [CNT_W-1:0] TRIG_CODE1 = 7'h10;
	localparam logic [CNT_W-1:0] TRIG_CODE2 = 7'h20;
	localparam logic [CNT_W-1:0] TRIG_CODE3 = 7'h30;

	// prescaler terminal counts: divide by 1, 4, 16, 64
	localparam logic [5:0] PRE_TERM0 = 6'h00;
	localparam logic [5:0] PRE_TERM1 = 6'h03;
	localparam logic [5:0] PRE_TERM2 = 6'h0f;
	localparam logic [5:0] PRE_TERM3 = 6'h3f;

	// half bit-period factors (factor/2): 32,10,22,26,58 async, 4 sync
	localparam logic [4:0] HALF_S16  = 5'h10;
	localparam logic [4:0] HALF_S5   = 5'h05;
	localparam logic [4:0] HALF_S11  = 5'h0b;
	localparam logic [4:0] HALF_S13  = 5'h0d;
	localparam logic [4:0] HALF_S29  = 5'h1d;
	localparam logic [4:0] HALF_SYNC = 5'h02;

	// idle timeout: 15 etu at 1/16 sampling
	localparam int         IDLE_ETU    = 15;
	localparam logic [4:0] ETU16_HALF  = HALF_S16;
	localparam logic [3:0] IDLE_ETU_CT = 4'(IDLE_ETU);

	typedef enum logic [2:0] {
		SRXB_SAMP_16 = 3'h0,
		SRXB_SAMP_5  = 3'h1,
		SRXB_SAMP_11 = 3'h2,
		SRXB_SAMP_13 = 3'h3,
		SRXB_SAMP_29 = 3'h4
	} srxb_samp_t;

	typedef struct packed {
		logic       sync_mode;
		logic [2:0] sampling;
		logic [1:0] prescale;
	} srxb_mode_t;

	typedef struct packed {
		logic fill;
		logic idle;
	} srxb_flags_t;
endpackage : srxb_pkg

// File: logic/srxb_mem.sv
module srxb_mem
	import srxb_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire logic [PTR_W-1:0] wr_addr,
	input  wire logic [7:0]       wr_data,
	input  wire logic [PTR_W-1:0] rd_addr,
	output logic      [7:0]       rd_data
);
	logic [7:0] store [FIFO_DEPTH];

	// no reset: content of an empty slot is undefined by design
	always_ff @(posedge clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= store[rd_addr];
	end
endmodule : srxb_mem

// File: logic/srxb_top.sv
module srxb_top
	import srxb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [15:0] bus_rdata,
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char_data,
	output logic             sample_tick,
	output logic             bit_tick,
	output logic             irq
);
	srxb_mode_t           mode;
	logic [7:0]           divisor;
	logic [1:0]           trig_code;
	srxb_flags_t          flags;
	srxb_flags_t          seen_one;
	logic [IRQ_WIDTH-1:0] irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask;

	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] fifo_count;
	logic [7:0]       mem_q;
	logic             rdata_from_fifo;
	logic [15:0]      rdata_reg;

	logic [5:0] pre_cnt;
	logic [7:0] div_cnt;
	logic [4:0] samp_cnt;
	logic [4:0] etu_cnt;
	logic [3:0] idle_etu;
	logic       idle_armed;

	logic [5:0]       pre_term;
	logic [4:0]       half_factor;
	logic [CNT_W-1:0] trig_level;
	logic             pre_tick;
	logic             etu16_tick;
	logic             fifo_full;
	logic             fifo_empty;
	logic             push;
	logic             pop;
	logic             overrun;
	logic             fifo_reset;
	logic             wr_status;
	logic             rd_status;
	logic             fill_set;
	logic             fill_clear;
	logic             idle_set;
	logic             idle_clear;
	logic             fill_rise;
	logic             fill_prev;

	assign wr_status = bus_wr && (bus_addr == ADDR_STATUS);
	assign rd_status = bus_rd && (bus_addr == ADDR_STATUS);

	// ---------------- baud generator ----------------

	always_comb begin
		unique case (mode.prescale)
			2'h0: pre_term = PRE_TERM0;
			2'h1: pre_term = PRE_TERM1;
			2'h2: pre_term = PRE_TERM2;
			2'h3: pre_term = PRE_TERM3;
		endcase
	end

	// factor*2^(2n-1) = (factor/2)*4^n, so the half factor counts sub ticks
	always_comb begin
		if (mode.sync_mode) begin
			half_factor = HALF_SYNC;
		end else begin
			unique case (mode.sampling)
				SRXB_SAMP_16: half_factor = HALF_S16;
				SRXB_SAMP_5:  half_factor = HALF_S5;
				SRXB_SAMP_11: half_factor = HALF_S11;
				SRXB_SAMP_13: half_factor = HALF_S13;
				SRXB_SAMP_29: half_factor = HALF_S29;
				// undefined sampling codes fall back to 1/16
				default:      half_factor = HALF_S16;
			endcase
		end
	end

	assign pre_tick    = (pre_cnt == pre_term);
	assign sample_tick = pre_tick && (div_cnt == divisor);
	assign bit_tick    = sample_tick && (samp_cnt == half_factor - 5'h01);
	assign etu16_tick  = sample_tick && (etu_cnt == ETU16_HALF - 5'h01);

	always_ff @(posedge clk) begin
		if (rst || pre_tick) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
		end
	end

	// divides the prescaled clock by divisor+1
	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt <= '0;
		end else if (sample_tick) begin
			div_cnt <= '0;
		end else if (pre_tick) begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || bit_tick) begin
			samp_cnt <= '0;
		end else if (sample_tick) begin
			samp_cnt <= samp_cnt + 5'h01;
		end
	end

	// idle timing always runs on 1/16 etu, whatever the sampling rate
	always_ff @(posedge clk) begin
		if (rst || rx_char_valid || etu16_tick) begin
			etu_cnt <= '0;
		end else if (sample_tick) begin
			etu_cnt <= etu_cnt + 5'h01;
		end
	end

	// ---------------- receive fifo ----------------

	assign fifo_full  = (fifo_count == FIFO_FULL);
	assign fifo_empty = (fifo_count == '0);
	assign push       = rx_char_valid && !fifo_full;
	assign overrun    = rx_char_valid && fifo_full;
	assign pop        = bus_rd && (bus_addr == ADDR_RXDATA) && !fifo_empty;
	assign fifo_reset = bus_wr && (bus_addr == ADDR_FCTRL) && bus_wdata[FC_RESET_BIT];

	srxb_mem u_mem (
		.clk     (clk),
		.wr_en   (push),
		.wr_addr (wr_ptr),
		.wr_data (rx_char_data),
		.rd_addr (rd_ptr),
		.rd_data (mem_q)
	);

	always_ff @(posedge clk) begin
		if (rst || fifo_reset) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 6'h01;
		end
	end

	// an empty read still returns whatever the slot holds
	always_ff @(posedge clk) begin
		if (rst || fifo_reset) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || fifo_reset) begin
			fifo_count <= '0;
		end else if (push && !pop) begin
			fifo_count <= fifo_count + 7'h01;
		end else if (pop && !push) begin
			fifo_count <= fifo_count - 7'h01;
		end
	end

	// ---------------- trigger and flags ----------------

	always_comb begin
		unique case (trig_code)
			2'h0: trig_level = TRIG_CODE0;
			2'h1: trig_level = TRIG_CODE1;
			2'h2: trig_level = TRIG_CODE2;
			2'h3: trig_level = TRIG_CODE3;
		endcase
	end

	// idle timer arms on each character, disarms once the flag fires
	always_ff @(posedge clk) begin
		if (rst || fifo_reset) begin
			idle_armed <= 1'b0;
			idle_etu   <= '0;
		end else if (rx_char_valid) begin
			idle_armed <= 1'b1;
			idle_etu   <= '0;
		end else if (idle_set) begin
			idle_armed <= 1'b0;
			idle_etu   <= '0;
		end else if (etu16_tick && idle_armed) begin
			idle_etu   <= idle_etu + 4'h1;
		end
	end

	assign fill_set = (fifo_count >= trig_level);
	assign idle_set = idle_armed && etu16_tick && !mode.sync_mode
		&& (idle_etu == IDLE_ETU_CT - 4'h1) && !fifo_empty
		&& (fifo_count < trig_level);

	// a written 1 is ignored; a 0 clears only after the flag was read as 1
	assign fill_clear = wr_status && !bus_wdata[ST_FILL_BIT] && seen_one.fill
		&& (fifo_count < trig_level);
	assign idle_clear = wr_status && !bus_wdata[ST_IDLE_BIT] && seen_one.idle
		&& fifo_empty;

	// set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			flags.fill <= 1'b0;
		end else begin
			flags.fill <= fill_set || (flags.fill && !fill_clear);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags.idle <= 1'b0;
		end else begin
			flags.idle <= idle_set || (flags.idle && !idle_clear);
		end
	end

	// remembers that software has seen each flag as 1
	always_ff @(posedge clk) begin
		if (rst) begin
			seen_one <= '0;
		end else begin
			if (!flags.fill || fill_clear) begin
				seen_one.fill <= 1'b0;
			end else if (rd_status) begin
				seen_one.fill <= 1'b1;
			end
			if (!flags.idle || idle_clear) begin
				seen_one.idle <= 1'b0;
			end else if (rd_status) begin
				seen_one.idle <= 1'b1;
			end
		end
	end

	// ---------------- interrupts ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			fill_prev <= 1'b0;
		end else begin
			fill_prev <= flags.fill;
		end
	end

	assign fill_rise = flags.fill && !fill_prev;

	// sticky events, write one to clear, a new event beats the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat <= '0;
		end else begin
			if (bus_wr && (bus_addr == ADDR_IRQ_STAT)) begin
				irq_stat <= (irq_stat & ~bus_wdata[IRQ_WIDTH-1:0])
					| {overrun, fill_rise, idle_set};
			end else begin
				irq_stat <= irq_stat | {overrun, fill_rise, idle_set};
			end
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ---------------- register writes ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			mode <= '0;
		end else if (bus_wr && (bus_addr == ADDR_MODE)) begin
			mode.prescale  <= bus_wdata[MODE_PRE_LSB +: 2];
			mode.sampling  <= bus_wdata[MODE_SAMP_LSB +: 3];
			mode.sync_mode <= bus_wdata[MODE_SYNC_BIT];
		end
	end

	// software keeps the divisor legal; sync mode with 0 is not guarded
	always_ff @(posedge clk) begin
		if (rst) begin
			divisor <= DIVISOR_RESET;
		end else if (bus_wr && (bus_addr == ADDR_DIVISOR)) begin
			divisor <= bus_wdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			trig_code <= '0;
		end else if (bus_wr && (bus_addr == ADDR_FCTRL)) begin
			trig_code <= bus_wdata[FC_TRIG_LSB +: 2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (bus_wr && (bus_addr == ADDR_IRQ_MASK)) begin
			irq_mask <= bus_wdata[IRQ_WIDTH-1:0];
		end
	end

	// ---------------- register reads ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg       <= '0;
			rdata_from_fifo <= 1'b0;
		end else if (bus_rd) begin
			rdata_from_fifo <= (bus_addr == ADDR_RXDATA);
			case (bus_addr)
				ADDR_MODE:     rdata_reg <= 16'(mode);
				ADDR_DIVISOR:  rdata_reg <= {8'h00, divisor};
				ADDR_STATUS:   rdata_reg <= 16'(flags);
				ADDR_FCTRL:    rdata_reg <= 16'({trig_code, 6'h00});
				ADDR_FCOUNT:   rdata_reg <= 16'(fifo_count);
				ADDR_IRQ_STAT: rdata_reg <= 16'(irq_stat);
				ADDR_IRQ_MASK: rdata_reg <= 16'(irq_mask);
				// unmapped addresses read as zero
				default:       rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg       <= '0;
			rdata_from_fifo <= 1'b0;
		end
	end

	// both sources are flops; the memory output already is a register
	assign bus_rdata = rdata_from_fifo ? {8'h00, mem_q} : rdata_reg;
endmodule : srxb_top
